// *** pkg/tcc_pkg.sv ***
/*
 * Constants, field layout and encodings of one compare/capture channel.
 * Assumes a 16-bit counter outside this block and a 32-bit APB master.
 */
// Functional notes
// - Sync select: 1 synchronous, 0 asynchronous capture
// - Buffer-load mode field; codes 5-7 reserved
// - Mode 0: load on next clock after write
// - Mode 1: load at MAX, zero, or both
// - Mode 2: load on match with buffer
// - Mode 3: load on wrap, or match/zero
// - Mode 4: load on match, force counter
// - Trigger source field used only when capturing
// - Trigger edge field picks capturing edges
// - Pin source: rise, fall or both edges
// - Source 2 to 3 rises, 3 to 2 falls
// - Edge code zero disables capture
// - Pair select uses both pair matches
// - Software mode drives high when level 1
// - Software mode drives low when level 0
// - Software level ignored in capture mode
package tcc_pkg;

    // ************************************************
    // Register map
    // ************************************************
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_VALUE = 12'h004;
    localparam logic [11:0] OFF_STAT = 12'h008;

    // ************************************************
    // Control fields
    // ************************************************
    localparam int POS_SYNC = 15;
    localparam int POS_BUF_MODE = 12;
    localparam int POS_SRC = 10;
    localparam int POS_EDGE = 8;
    localparam int POS_PAIR = 6;
    localparam int POS_SW_LEVEL = 5;
    localparam int POS_OUT_MODE = 2;
    localparam int POS_INVERT = 1;
    localparam int POS_CAP_MODE = 0;
    localparam logic [15:0] CTRL_WMASK = 16'hFF7F;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] VALUE_RESET = 16'h0000;
    localparam logic [15:0] ZERO_COUNT = 16'h0000;

    typedef enum logic [2:0] {
        BUF_ON_WRITE = 3'h0,
        BUF_AT_END = 3'h1,
        BUF_AT_MATCH = 3'h2,
        BUF_AT_WRAP = 3'h3,
        BUF_MATCH_RESTART = 3'h4,
        BUF_RSV5 = 3'h5,
        BUF_RSV6 = 3'h6,
        BUF_RSV7 = 3'h7
    } buf_mode_e;

    typedef enum logic [1:0] {
        SRC_PIN = 2'h0,
        SRC_NONE = 2'h1,
        SRC_SW_LOW = 2'h2,
        SRC_SW_HIGH = 2'h3
    } trig_src_e;

    typedef enum logic [1:0] {
        DIR_UP = 2'h0,
        DIR_DOWN = 2'h1,
        DIR_UPDOWN = 2'h2
    } count_dir_e;

endpackage : tcc_pkg

// *** pkg/pin_edge_if.sv ***
/*
 * Carries the filtered capture pin level and its edge pulses.
 * Assumes producer and consumer share pclk.
 */
`timescale 1ns/100ps
interface pin_edge_if;
    logic level;
    logic rise;
    logic fall;
    modport source (output level, output rise, output fall);
    modport sink (input level, input rise, input fall);
endinterface : pin_edge_if

// *** verilog/capture_pin_sync.sv ***
/*
 * Three-stage synchroniser and edge detector for the capture pin.
 * Assumes the pin is asynchronous to pclk.
 */
`timescale 1ns/100ps
module capture_pin_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin_raw,
    pin_edge_if.source ev
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
        logic rise;
        logic fall;
    } sync_s;

    sync_s st_q;
    sync_s st_d;

    // ************************************************
    // Filter: a change counts once stages two and three agree
    // ************************************************
    always_comb begin
        st_d = st_q;
        st_d.s1 = pin_raw;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        st_d.rise = 1'b0;
        st_d.fall = 1'b0;
        if (st_q.s2 == st_q.s3 && st_q.s3 != st_q.level) begin
            st_d.level = st_q.s3;
            st_d.rise = st_q.s3;
            st_d.fall = ~st_q.s3;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign ev.level = st_q.level;
    assign ev.rise = st_q.rise;
    assign ev.fall = st_q.fall;

endmodule : capture_pin_sync

// *** verilog/timer_compare_capture_channel_ctrl.sv ***
/*
 * One compare/capture channel control: APB registers, compare buffer
 * loading, capture triggering and timer output generation.
 * Assumes the counter, its direction and MAX value come from the timer
 * core on pclk, which serves as the timer count clock.
 */
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module timer_compare_capture_channel_ctrl #(
    parameter int CNT_W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [CNT_W-1:0] counter_value,
    input wire logic [CNT_W-1:0] counter_max,
    input wire logic [1:0] count_dir,
    input wire logic partner_match,
    input wire logic capture_input_pin,
    output logic [CNT_W-1:0] compare_buffer,
    output logic match_out,
    output logic counter_force_zero,
    output logic counter_force_max,
    output logic capture_strobe,
    output logic timer_output_signal
);

    typedef struct packed {
        logic [15:0] ctrl;
        logic [CNT_W-1:0] value;
        logic [CNT_W-1:0] captured;
        logic [CNT_W-1:0] buffer;
        logic [CNT_W-1:0] cnt_d1;
        logic [CNT_W-1:0] cnt_d2;
        logic load_pend;
        logic out_lvl;
        logic match;
        logic force_zero;
        logic force_max;
        logic cap_pulse;
        logic tout;
        logic ready;
        logic slverr;
        logic [31:0] rdata;
    } chan_s;

    chan_s st_q;
    chan_s st_d;

    pin_edge_if pin_ev ();

    capture_pin_sync u_pin_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin_raw(capture_input_pin),
        .ev(pin_ev)
    );

    // ************************************************
    // Decoded control fields
    // ************************************************
    logic sync_sel;
    tcc_pkg::buf_mode_e buf_mode;
    tcc_pkg::trig_src_e trig_src;
    logic [1:0] trig_edge;
    logic pair_sel;
    logic sw_level;
    logic [2:0] out_mode;
    logic out_inv;
    logic cap_mode;
    tcc_pkg::count_dir_e dir;

    assign sync_sel = st_q.ctrl[tcc_pkg::POS_SYNC];
    assign buf_mode = tcc_pkg::buf_mode_e'(st_q.ctrl[tcc_pkg::POS_BUF_MODE +: 3]);
    assign trig_src = tcc_pkg::trig_src_e'(st_q.ctrl[tcc_pkg::POS_SRC +: 2]);
    assign trig_edge = st_q.ctrl[tcc_pkg::POS_EDGE +: 2];
    assign pair_sel = st_q.ctrl[tcc_pkg::POS_PAIR];
    assign sw_level = st_q.ctrl[tcc_pkg::POS_SW_LEVEL];
    assign out_mode = st_q.ctrl[tcc_pkg::POS_OUT_MODE +: 3];
    assign out_inv = st_q.ctrl[tcc_pkg::POS_INVERT];
    assign cap_mode = st_q.ctrl[tcc_pkg::POS_CAP_MODE];
    assign dir = tcc_pkg::count_dir_e'(count_dir);

    // ************************************************
    // APB access decode
    // ************************************************
    logic acc;
    logic wr_commit;
    logic wr_ctrl;
    logic wr_value;
    logic addr_ok;

    // One wait state: pready rises in the second access cycle
    assign acc = psel & penable;
    assign wr_commit = acc & st_q.ready & pwrite;
    assign wr_ctrl = wr_commit && paddr == tcc_pkg::OFF_CTRL;
    assign wr_value = wr_commit && paddr == tcc_pkg::OFF_VALUE;
    assign addr_ok = paddr == tcc_pkg::OFF_CTRL || paddr == tcc_pkg::OFF_VALUE
        || paddr == tcc_pkg::OFF_STAT;

    // ************************************************
    // Counter events
    // ************************************************
    logic at_zero;
    logic at_max;
    logic cmp_hit;

    assign at_zero = counter_value == tcc_pkg::ZERO_COUNT;
    assign at_max = counter_value == counter_max;
    assign cmp_hit = ~cap_mode & (counter_value == st_q.buffer);

    // ************************************************
    // Software trigger edges from source field writes
    // ************************************************
    logic [1:0] new_src;
    logic sw_rise;
    logic sw_fall;

    assign new_src = pwdata[tcc_pkg::POS_SRC +: 2];
    always_comb begin
        sw_rise = 1'b0;
        sw_fall = 1'b0;
        if (wr_ctrl) begin
            sw_rise = trig_src == tcc_pkg::SRC_SW_LOW
                && new_src == tcc_pkg::SRC_SW_HIGH;
            sw_fall = trig_src == tcc_pkg::SRC_SW_HIGH
                && new_src == tcc_pkg::SRC_SW_LOW;
        end
    end

    // ************************************************
    // Capture trigger
    // ************************************************
    logic trig_rise;
    logic trig_fall;
    logic cap_fire;

    always_comb begin
        trig_rise = 1'b0;
        trig_fall = 1'b0;
        unique case (trig_src)
            tcc_pkg::SRC_PIN: begin
                trig_rise = pin_ev.rise;
                trig_fall = pin_ev.fall;
            end
            tcc_pkg::SRC_NONE: begin
                trig_rise = 1'b0;
                trig_fall = 1'b0;
            end
            tcc_pkg::SRC_SW_LOW, tcc_pkg::SRC_SW_HIGH: begin
                trig_rise = sw_rise;
                trig_fall = sw_fall;
            end
        endcase
    end

    // Edge code bit 0 selects rising, bit 1 falling; zero disables
    assign cap_fire = cap_mode & ((trig_edge[0] & trig_rise)
        | (trig_edge[1] & trig_fall));

    // ************************************************
    // Compare buffer load timing
    // ************************************************
    logic load_ev;
    logic restart;

    always_comb begin
        load_ev = 1'b0;
        restart = 1'b0;
        unique case (buf_mode)
            tcc_pkg::BUF_ON_WRITE: begin
                load_ev = st_q.load_pend;
            end
            tcc_pkg::BUF_AT_END: begin
                unique case (dir)
                    tcc_pkg::DIR_UP: load_ev = at_max;
                    tcc_pkg::DIR_DOWN: load_ev = at_zero;
                    default: load_ev = at_zero | at_max;
                endcase
            end
            tcc_pkg::BUF_AT_MATCH: begin
                load_ev = cmp_hit;
            end
            tcc_pkg::BUF_AT_WRAP: begin
                unique case (dir)
                    tcc_pkg::DIR_UP: load_ev = at_zero;
                    tcc_pkg::DIR_DOWN: load_ev = at_max;
                    default: load_ev = cmp_hit | at_zero;
                endcase
            end
            tcc_pkg::BUF_MATCH_RESTART: begin
                load_ev = cmp_hit;
                restart = cmp_hit;
            end
            default: begin
                load_ev = 1'b0;
                restart = 1'b0;
            end
        endcase
        if (cap_mode) begin
            load_ev = 1'b0;
            restart = 1'b0;
        end
    end

    // ************************************************
    // Timer output events
    // ************************************************
    logic end_ev;
    logic set_ev;
    logic clr_ev;
    logic tgl_ev;
    logic next_lvl;

    assign end_ev = dir == tcc_pkg::DIR_DOWN ? at_zero : at_max;

    // Paired mode swaps the counter end event for the partner match in modes 2, 3, 6, 7; modes 1, 4, 5 add it to the compare hit
    always_comb begin
        set_ev = 1'b0;
        clr_ev = 1'b0;
        tgl_ev = 1'b0;
        next_lvl = st_q.out_lvl;
        unique case (out_mode)
            3'h7: begin
                clr_ev = cmp_hit;
                set_ev = pair_sel ? partner_match : end_ev;
            end
            3'h6: begin
                tgl_ev = cmp_hit;
                set_ev = pair_sel ? partner_match : end_ev;
            end
            3'h5: begin
                clr_ev = cmp_hit | (pair_sel & partner_match);
            end
            3'h4: begin
                tgl_ev = cmp_hit | (pair_sel & partner_match);
            end
            3'h3: begin
                set_ev = cmp_hit;
                clr_ev = pair_sel ? partner_match : end_ev;
            end
            3'h2: begin
                tgl_ev = cmp_hit;
                clr_ev = pair_sel ? partner_match : end_ev;
            end
            3'h1: begin
                set_ev = cmp_hit | (pair_sel & partner_match);
            end
            3'h0: begin
                set_ev = 1'b0;
            end
        endcase
        if (out_mode == 3'h0) begin
            next_lvl = sw_level;
        end else if (tgl_ev) begin
            next_lvl = ~st_q.out_lvl;
        end else if (set_ev) begin
            next_lvl = 1'b1;
        end else if (clr_ev) begin
            next_lvl = 1'b0;
        end
    end

    // ************************************************
    // Read data
    // ************************************************
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (paddr == tcc_pkg::OFF_CTRL) begin
            rd_mux[15:0] = st_q.ctrl & tcc_pkg::CTRL_WMASK;
        end else if (paddr == tcc_pkg::OFF_VALUE) begin
            rd_mux[CNT_W-1:0] = cap_mode ? st_q.captured : st_q.value;
        end else if (paddr == tcc_pkg::OFF_STAT) begin
            rd_mux[CNT_W-1:0] = st_q.buffer;
            rd_mux[16] = pin_ev.level;
            rd_mux[17] = st_q.load_pend;
        end
    end

    // ************************************************
    // Next state
    // ************************************************
    always_comb begin
        st_d = st_q;
        st_d.cnt_d1 = counter_value;
        st_d.cnt_d2 = st_q.cnt_d1;
        st_d.ready = acc & ~st_q.ready;
        st_d.slverr = acc & ~st_q.ready & ~addr_ok;
        st_d.rdata = (acc & ~st_q.ready & ~pwrite) ? rd_mux : 32'h0000_0000;
        if (wr_ctrl) begin
            st_d.ctrl = pwdata[15:0] & tcc_pkg::CTRL_WMASK;
        end
        if (wr_value) begin
            st_d.value = pwdata[CNT_W-1:0];
        end
        // A write in the load cycle stays pending for the next edge
        if (wr_value) begin
            st_d.load_pend = 1'b1;
        end else if (load_ev) begin
            st_d.load_pend = 1'b0;
        end
        if (load_ev) begin
            st_d.buffer = st_q.value;
        end
        st_d.match = cmp_hit;
        st_d.force_zero = restart & (dir != tcc_pkg::DIR_DOWN);
        st_d.force_max = restart & (dir == tcc_pkg::DIR_DOWN);
        // Async mode keeps the count from two cycles before the filtered edge,
        // sync mode the count at the filtered edge
        st_d.cap_pulse = cap_fire;
        if (cap_fire) begin
            st_d.captured = sync_sel ? counter_value : st_q.cnt_d2;
        end
        if (!cap_mode) begin
            st_d.out_lvl = next_lvl;
        end
        st_d.tout = cap_mode ? 1'b0 : (st_d.out_lvl ^ out_inv);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
            st_q.ctrl <= tcc_pkg::CTRL_RESET;
            st_q.value <= tcc_pkg::VALUE_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // ************************************************
    // Outputs
    // ************************************************
    assign prdata = st_q.rdata;
    assign pready = st_q.ready;
    assign pslverr = st_q.slverr;
    assign compare_buffer = st_q.buffer;
    assign match_out = st_q.match;
    assign counter_force_zero = st_q.force_zero;
    assign counter_force_max = st_q.force_max;
    assign capture_strobe = st_q.cap_pulse;
    assign timer_output_signal = st_q.tout;

endmodule : timer_compare_capture_channel_ctrl

// *** verification/tcc_checker.sv ***
/* Port-level assertions for one compare/capture channel.
   Assumes only the top ports; control is mirrored from APB writes. */
`timescale 1ns/100ps
module tcc_checker #(
    parameter int CNT_W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [CNT_W-1:0] counter_value,
    input wire logic [1:0] count_dir,
    input wire logic [CNT_W-1:0] compare_buffer,
    input wire logic counter_force_zero,
    input wire logic counter_force_max,
    input wire logic match_out,
    input wire logic capture_strobe,
    input wire logic timer_output_signal
);
    // ****************
    // Control mirror
    // ****************
    logic [15:0] ctrl_q;
    logic wr_ok;
    logic cmp_mode;
    logic sw_out;
    assign wr_ok = psel && penable && pready && pwrite && !pslverr;
    assign cmp_mode = !ctrl_q[tcc_pkg::POS_CAP_MODE];
    assign sw_out = cmp_mode && ctrl_q[4:2] == 3'h0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 16'h0000;
        end else if (wr_ok && paddr == tcc_pkg::OFF_CTRL) begin
            ctrl_q <= pwdata[15:0] & tcc_pkg::CTRL_WMASK;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_value_commit;
        wr_ok && paddr == tcc_pkg::OFF_VALUE;
    endsequence
    sequence s_restart_match;
        cmp_mode && ctrl_q[14:12] == 3'h4 && counter_value == compare_buffer;
    endsequence
    property p_load_on_write;
        s_value_commit ##0 (cmp_mode && ctrl_q[14:12] == 3'h0)
            |-> ##2 compare_buffer == $past(pwdata[15:0], 2);
    endproperty
    property p_reserved_hold;
        cmp_mode && ctrl_q[14:12] >= 3'h5 && $stable(ctrl_q) |=> $stable(compare_buffer);
    endproperty
    property p_force_zero;
        s_restart_match ##0 count_dir != 2'h1 |=> counter_force_zero;
    endproperty
    property p_force_max;
        s_restart_match ##0 count_dir == 2'h1 |=> counter_force_max;
    endproperty
    // The strobe reflects the control word of the cycle before it
    property p_edge_needed;
        capture_strobe |-> $past(ctrl_q[9:8]) != 2'h0;
    endproperty
    property p_capture_only;
        capture_strobe |-> $past(!cmp_mode);
    endproperty
    property p_match_flag;
        presetn |=> match_out == $past(cmp_mode && counter_value == compare_buffer);
    endproperty
    property p_sw_high;
        sw_out && ctrl_q[5] && $stable(ctrl_q) |-> timer_output_signal == !ctrl_q[1];
    endproperty
    property p_sw_low;
        sw_out && !ctrl_q[5] && $stable(ctrl_q) |-> timer_output_signal == ctrl_q[1];
    endproperty
    property p_capture_quiet;
        !cmp_mode && $stable(ctrl_q) |-> !timer_output_signal;
    endproperty
    property p_bit7_zero;
        pready && psel && !pwrite && paddr == tcc_pkg::OFF_CTRL |-> !prdata[7];
    endproperty
    a_load_on_write: assert property (p_load_on_write)
        else $error("buffer not loaded after value write");
    a_reserved_hold: assert property (p_reserved_hold)
        else $error("buffer changed in reserved mode");
    a_force_zero: assert property (p_force_zero)
        else $error("no zero restart on match");
    a_force_max: assert property (p_force_max)
        else $error("no max restart on match");
    a_edge_needed: assert property (p_edge_needed)
        else $error("capture with edge code zero");
    a_capture_only: assert property (p_capture_only)
        else $error("capture in comparator mode");
    a_sw_high: assert property (p_sw_high)
        else $error("software output not high");
    a_sw_low: assert property (p_sw_low)
        else $error("software output not low");
    a_capture_quiet: assert property (p_capture_quiet)
        else $error("output active in capture mode");
    a_bit7_zero: assert property (p_bit7_zero)
        else $error("control bit 7 read as one");
    a_match_flag: assert property (p_match_flag)
        else $error("match flag does not follow compare");
endmodule : tcc_checker
bind timer_compare_capture_channel_ctrl tcc_checker #(.CNT_W(CNT_W)) checker_u (.*);

// *** verification/timer_core_model.sv ***
/* Behavioural counter of the timer core facing the channel.
   Assumes max above one; honours the channel's restart pulses. */
`timescale 1ns/100ps
module timer_core_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] count_dir,
    input wire logic [15:0] counter_max,
    input wire logic force_zero,
    input wire logic force_max,
    output logic [15:0] counter_value
);
    // ****************
    // Counter
    // ****************
    logic fall_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_value <= 16'h0000;
            fall_q <= 1'b0;
        end else if (force_zero) begin
            counter_value <= 16'h0000;
            fall_q <= 1'b0;
        end else if (force_max) begin
            counter_value <= counter_max;
        end else if (count_dir == 2'h1) begin
            counter_value <= counter_value == 16'h0000 ? counter_max : counter_value - 16'h0001;
        end else if (count_dir == 2'h0) begin
            counter_value <= counter_value >= counter_max ? 16'h0000 : counter_value + 16'h0001;
        end else if (fall_q || counter_value >= counter_max) begin
            // Turning at the top keeps up/down traffic inside the range
            counter_value <= counter_value - 16'h0001;
            fall_q <= counter_value > 16'h0001;
        end else begin
            counter_value <= counter_value + 16'h0001;
            fall_q <= counter_value + 16'h0001 >= counter_max;
        end
    end
endmodule : timer_core_model

// *** verification/timer_compare_capture_channel_ctrl_tb.sv ***
/* Self-checking bench of one compare/capture channel.
   Assumes the core model drives the counter; the pin is driven here. */
`timescale 1ns/100ps
module timer_compare_capture_channel_ctrl_tb;
    localparam logic [15:0] MAXV = 16'h0013;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic pin = 1'b0, pm = 1'b0, pready, pslverr, err, fz, fm, strobe, tout;
    logic [47:0] hist, caps;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, rd;
    logic [1:0] dir = 2'h0;
    logic [15:0] cnt, cbuf, last;
    int failures = 0, compares = 0, cycles = 0, strobes = 0;
    always #2 pclk = ~pclk;
    timer_compare_capture_channel_ctrl #(.CNT_W(16)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .counter_value(cnt), .counter_max(MAXV), .count_dir(dir), .partner_match(pm),
        .capture_input_pin(pin), .compare_buffer(cbuf), .match_out(),
        .counter_force_zero(fz), .counter_force_max(fm), .capture_strobe(strobe),
        .timer_output_signal(tout));
    timer_core_model core_u (.pclk(pclk), .presetn(presetn), .count_dir(dir),
        .counter_max(MAXV), .force_zero(fz), .force_max(fm), .counter_value(cnt));
    // ****************
    // Shared tasks
    // ****************
    task automatic summarize();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic e);
        apb(1'b0, a, 32'h00000000);
        check(rd, exp);
        check({31'h00000000, err}, {31'h00000000, e});
    endtask : rchk
    task automatic step(input logic [15:0] c, input logic p, input logic e);
        int s;
        s = strobes;
        apb(1'b1, tcc_pkg::OFF_CTRL, {16'h0000, c});
        pin <= p;
        repeat (12) @(posedge pclk);
        check(strobes - s, {31'h00000000, e});
    endtask : step
    // ****************
    // Scenarios
    // ****************
    task automatic t_regs();
        rchk(tcc_pkg::OFF_CTRL, 32'h00000000, 1'b0);
        apb(1'b1, tcc_pkg::OFF_CTRL, 32'hFFFFF3FF);
        rchk(tcc_pkg::OFF_CTRL, 32'h0000F37F, 1'b0);
        rchk(12'hFFC, 32'h00000000, 1'b1);
        apb(1'b1, tcc_pkg::OFF_CTRL, 32'h00000000);
        $display("test regs done");
    endtask : t_regs
    task automatic t_out();
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, tcc_pkg::OFF_CTRL, {26'h0000000, i[1], 4'h0, i[0]});
            repeat (2) @(posedge pclk);
            check({31'h00000000, tout}, {31'h00000000, i[1] & !i[0]});
        end
        $display("test output done");
    endtask : t_out
    task automatic t_buffer();
        apb(1'b1, tcc_pkg::OFF_CTRL, 32'h00000000);
        apb(1'b1, tcc_pkg::OFF_VALUE, 32'h00000005);
        repeat (2) @(posedge pclk);
        check({16'h0000, cbuf}, 32'h00000005);
        for (int d = 0; d < 3; d++) begin
            for (int m = 1; m < 5; m++) begin
                last = 16'(m + 4 * d + 2);
                dir <= d[1:0];
                apb(1'b1, tcc_pkg::OFF_CTRL, {17'h00000, m[2:0], 12'h000});
                apb(1'b1, tcc_pkg::OFF_VALUE, {16'h0000, last});
                repeat (60) @(posedge pclk);
                check({16'h0000, cbuf}, {16'h0000, last});
            end
        end
        // Reserved codes first, else the value write would load in mode 4
        for (int m = 5; m < 8; m++) begin
            apb(1'b1, tcc_pkg::OFF_CTRL, {17'h00000, m[2:0], 12'h000});
            apb(1'b1, tcc_pkg::OFF_VALUE, 32'h00000011);
            repeat (40) @(posedge pclk);
            check({16'h0000, cbuf}, {16'h0000, last});
        end
        $display("test buffer done");
    endtask : t_buffer
    task automatic t_capture();
        for (int e = 0; e < 4; e++) begin
            step({6'h00, e[1:0], 8'h01}, 1'b0, 1'b0);
            step({6'h00, e[1:0], 8'h01}, 1'b1, e[0]);
            step({6'h00, e[1:0], 8'h01}, 1'b0, e[1]);
            step({6'h02, e[1:0], 8'h01}, 1'b0, 1'b0);
            step({6'h03, e[1:0], 8'h01}, 1'b0, e[0]);
            step({6'h02, e[1:0], 8'h01}, 1'b0, e[1]);
        end
        step(16'h0300, 1'b1, 1'b0);
        step(16'h0300, 1'b0, 1'b0);
        step(16'h8301, 1'b1, 1'b1);
        // Sync keeps the count at the capture edge, async two cycles earlier
        rchk(tcc_pkg::OFF_VALUE, {16'h0000, caps[15:0]}, 1'b0);
        step(16'h0301, 1'b0, 1'b1);
        rchk(tcc_pkg::OFF_VALUE, {16'h0000, caps[47:32]}, 1'b0);
        $display("test capture done");
    endtask : t_capture
    task automatic t_pair();
        apb(1'b1, tcc_pkg::OFF_CTRL, 32'h00000000);
        apb(1'b1, tcc_pkg::OFF_VALUE, 32'h00000100);
        apb(1'b1, tcc_pkg::OFF_CTRL, 32'h00000004);
        pm <= 1'b1;
        repeat (3) @(posedge pclk);
        check({31'h00000000, tout}, 32'h00000000);
        apb(1'b1, tcc_pkg::OFF_CTRL, 32'h00000044);
        repeat (3) @(posedge pclk);
        check({31'h00000000, tout}, 32'h00000001);
        pm <= 1'b0;
        $display("test pair done");
    endtask : t_pair
    always @(posedge pclk) begin
        cycles++;
        if (strobe === 1'b1) begin
            strobes++;
            caps = hist;
        end
        hist = {hist[31:0], cnt};
        if (cycles == 20000) begin
            failures++;
            summarize();
        end
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_out();
        t_buffer();
        t_capture();
        t_pair();
        summarize();
    end
endmodule : timer_compare_capture_channel_ctrl_tb
